//--- verilog/uce_pkg.sv
/*
  uce_pkg: constants and carrier types for the control endpoint engine.
  assumes a serial interface engine decodes tokens and packets for it.
*/
package uce_pkg;
  // register offsets
  localparam logic [7:0] OFF_FUNC_ADDR = 8'h00;
  localparam logic [7:0] OFF_CTRL_CS   = 8'h01;
  localparam logic [7:0] OFF_EP_SEL    = 8'h02;
  localparam logic [7:0] OFF_RX_COUNT  = 8'h03;
  localparam logic [7:0] OFF_IRQ_COMM  = 8'h04;
  localparam logic [7:0] OFF_IRQ_IN    = 8'h05;
  localparam logic [7:0] OFF_IRQ_OUT   = 8'h06;
  localparam logic [7:0] OFF_IN_LOW    = 8'h07;
  localparam logic [7:0] OFF_IN_HIGH   = 8'h08;
  localparam logic [7:0] OFF_OUT_LOW   = 8'h09;
  localparam logic [7:0] OFF_OUT_HIGH  = 8'h0a;
  // ctrl_ep_status_reg fields
  localparam int CS_RX_READY    = 0;
  localparam int CS_TX_READY    = 1;
  localparam int CS_STALL_SENT  = 2;
  localparam int CS_STALL_REQ   = 3;
  localparam int CS_LAST_DATA   = 4;
  localparam int CS_SETUP_ABORT = 5;
  localparam int CS_RX_RELEASE  = 6;
  localparam int CS_ABORT_CLEAR = 7;
  // indexed endpoint fields and interrupt flag bits
  localparam int EP_DIR_EN_BIT  = 0;
  localparam int EP_ISO_BIT     = 6;
  localparam int COMM_RESUME    = 1;
  localparam int EP0_IRQ_BIT    = 0;
  // sizes and reset values
  localparam logic [6:0] SETUP_LEN   = 7'h08;
  localparam logic [6:0] EP0_MAX_PKT = 7'h20;
  localparam logic [2:0] EP_LAST     = 3'h5;
  localparam logic [6:0] ADDR_RESET  = 7'h00;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  typedef enum logic [1:0] {
    UCE_PID_SETUP = 2'h0,
    UCE_PID_OUT   = 2'h1,
    UCE_PID_IN    = 2'h2,
    UCE_PID_NONE  = 2'h3
  } uce_pid_type;

  typedef enum logic [2:0] {
    UCE_RSP_NONE  = 3'h0,
    UCE_RSP_ACK   = 3'h1,
    UCE_RSP_NAK   = 3'h2,
    UCE_RSP_STALL = 3'h3,
    UCE_RSP_DATA  = 3'h4
  } uce_rsp_type;

  // gray codes along idle -> tx -> status -> rx -> idle
  typedef enum logic [1:0] {
    UCE_ST_IDLE   = 2'h0,
    UCE_ST_TX     = 2'h1,
    UCE_ST_STATUS = 2'h3,
    UCE_ST_RX     = 2'h2
  } uce_state_type;

  typedef struct packed {
    logic        valid;
    uce_pid_type pid;
    logic [6:0]  addr;
    logic [3:0]  ep;
  } uce_token_type;

  typedef struct packed {
    logic       done;
    logic [6:0] len;
    logic       data1;
    logic       setup_dir_in;
  } uce_packet_type;

  typedef struct packed {
    uce_rsp_type kind;
    logic        zlp;
    logic        ep_pass;
    logic        ep_iso;
  } uce_resp_type;
endpackage

//--- verilog/uce_engine.sv
/*
  uce_engine: usb control endpoint engine with endpoint 1-5 selection.
  assumes an engine upstream that decodes tokens, packet ends and
  host acks, and firmware on a plain strobe register port.
*/
// Chosen here: strobed register access and the register addresses.
// How it works
// - resume seen on the bus gives a rising edge on port 0 bit 7.
// - with address zero only the control endpoint carries traffic.
// - a non-zero address moves to addressed; configured endpoints open.
// - control endpoint is one direction at a time, 32 byte packets.
// - control interrupt on receive, sent, in done, stall sent, abort.
// - protocol error answers stall, sets stall-sent, raises interrupt.
// - tokens after last data, oversize out, nonzero status are errors.
// - stall request makes control in and out tokens answer with stall; setup is still taken.
// - unexpected token in data stage sets abort, interrupt, back to idle.
// - a setup packet must be 8 bytes, otherwise it is rejected.
// - release without last data enters tx or rx by setup direction.
// - a received setup or data packet sets receive-ready and interrupts.
// - tx takes only in, rx only out; firmware last data ends data stage.
// - each sent packet clears transmit-ready and interrupts once.
// - last data with transmit-ready starts status; idle when it ends.
// - in token in tx without transmit-ready is answered with nak.
// - endpoints 1-5 in, out or both, each iso or bulk/interrupt.
// - interrupt flag registers clear themselves when read.
`timescale 1ns/100ps
module uce_engine (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                usb_enable_in,
  input  wire logic [7:0]          addr_in,
  input  wire logic [7:0]          wr_data_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic      [7:0]          rd_data_out,
  input  wire uce_pkg::uce_token_type  tok_in,
  input  wire uce_pkg::uce_packet_type pkt_in,
  input  wire logic                in_ack_in,
  input  wire logic                resume_in,
  output uce_pkg::uce_resp_type    resp_out,
  output logic                     port0_bit7_out,
  output logic                     addressed_out
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic                  clr;
  logic [6:0]            func_addr_q;
  logic [2:0]            ep_sel_q;
  logic [5:1]            in_en_q;
  logic [5:1]            in_iso_q;
  logic [5:1]            out_en_q;
  logic [5:1]            out_iso_q;
  uce_pkg::uce_state_type state_q;
  uce_pkg::uce_pid_type  expect_q;
  uce_pkg::uce_resp_type resp_q;
  logic                  rx_rdy_q;
  logic                  tx_rdy_q;
  logic                  stall_sent_q;
  logic                  stall_req_q;
  logic                  last_q;
  logic                  abort_q;
  logic                  dir_in_q;
  logic                  status_in_q;
  logic                  in_wait_q;
  logic                  ep0_irq_q;
  logic [5:0]            rx_count_q;
  logic                  resume_q;
  logic                  irq_ep0_flag_q;
  logic                  irq_resume_flag_q;
  logic [7:0]            rd_data_q;
  logic [7:0]            rd_data_d;
  logic                  ep0_tok;
  logic                  data_tok;
  logic                  idx_ok;
  logic                  cs_wr;
  logic [2:0]            tok_ep3;

  // disable acts as a reset of the whole engine
  assign clr = rst_in | ~usb_enable_in;
  assign addressed_out = (func_addr_q != uce_pkg::ADDR_RESET);
  assign tok_ep3 = tok_in.ep[2:0];
  assign ep0_tok = tok_in.valid && (tok_in.addr == func_addr_q) &&
                   (tok_in.ep == 4'h0);
  assign data_tok = tok_in.valid && (tok_in.addr == func_addr_q) &&
                    (tok_in.ep != 4'h0) && (tok_in.ep[3] == 1'b0) &&
                    (tok_ep3 <= uce_pkg::EP_LAST);
  assign idx_ok = (ep_sel_q != 3'h0) && (ep_sel_q <= uce_pkg::EP_LAST);
  assign cs_wr = wr_in && hit(addr_in, uce_pkg::OFF_CTRL_CS);
  assign resp_out = resp_q;
  assign rd_data_out = rd_data_q;

  // plain configuration registers
  always_ff @(posedge clk_in) begin
    if (clr) begin
      func_addr_q <= uce_pkg::ADDR_RESET;
      ep_sel_q    <= 3'h0;
      in_en_q     <= 5'h00;
      in_iso_q    <= 5'h00;
      out_en_q    <= 5'h00;
      out_iso_q   <= 5'h00;
    end else if (wr_in) begin
      if (hit(addr_in, uce_pkg::OFF_FUNC_ADDR))
        func_addr_q <= wr_data_in[6:0];
      if (hit(addr_in, uce_pkg::OFF_EP_SEL))
        ep_sel_q <= wr_data_in[2:0];
      if (idx_ok) begin
        if (hit(addr_in, uce_pkg::OFF_IN_LOW))
          in_en_q[ep_sel_q] <= wr_data_in[uce_pkg::EP_DIR_EN_BIT];
        if (hit(addr_in, uce_pkg::OFF_IN_HIGH))
          in_iso_q[ep_sel_q] <= wr_data_in[uce_pkg::EP_ISO_BIT];
        if (hit(addr_in, uce_pkg::OFF_OUT_LOW))
          out_en_q[ep_sel_q] <= wr_data_in[uce_pkg::EP_DIR_EN_BIT];
        if (hit(addr_in, uce_pkg::OFF_OUT_HIGH))
          out_iso_q[ep_sel_q] <= wr_data_in[uce_pkg::EP_ISO_BIT];
      end
    end
  end

  // resume wake edge; level follows the bus so each resume gives an edge
  always_ff @(posedge clk_in) begin
    resume_q       <= resume_in && !clr;
    port0_bit7_out <= resume_in && !clr;
  end

  // control endpoint engine
  always_ff @(posedge clk_in) begin
    if (clr) begin
      state_q      <= uce_pkg::UCE_ST_IDLE;
      expect_q     <= uce_pkg::UCE_PID_NONE;
      resp_q       <= '0;
      rx_rdy_q     <= 1'b0;
      tx_rdy_q     <= 1'b0;
      stall_sent_q <= 1'b0;
      stall_req_q  <= 1'b0;
      last_q       <= 1'b0;
      abort_q      <= 1'b0;
      dir_in_q     <= 1'b0;
      status_in_q  <= 1'b0;
      in_wait_q    <= 1'b0;
      ep0_irq_q    <= 1'b0;
      rx_count_q   <= 6'h00;
    end else begin
      resp_q    <= '0;
      ep0_irq_q <= 1'b0;
      // firmware side first, so hardware events below win the same cycle
      if (cs_wr) begin
        stall_req_q <= wr_data_in[uce_pkg::CS_STALL_REQ];
        if (wr_data_in[uce_pkg::CS_TX_READY])
          tx_rdy_q <= 1'b1;
        if (wr_data_in[uce_pkg::CS_LAST_DATA])
          last_q <= 1'b1;
        if (!wr_data_in[uce_pkg::CS_STALL_SENT])
          stall_sent_q <= 1'b0;
        if (wr_data_in[uce_pkg::CS_ABORT_CLEAR])
          abort_q <= 1'b0;
        if (wr_data_in[uce_pkg::CS_RX_RELEASE]) begin
          rx_rdy_q <= 1'b0;
          if (state_q == uce_pkg::UCE_ST_IDLE &&
              !wr_data_in[uce_pkg::CS_LAST_DATA]) begin
            state_q <= dir_in_q ? uce_pkg::UCE_ST_TX
                                : uce_pkg::UCE_ST_RX;
          end
          if (state_q == uce_pkg::UCE_ST_RX &&
              wr_data_in[uce_pkg::CS_LAST_DATA]) begin
            state_q     <= uce_pkg::UCE_ST_STATUS;
            status_in_q <= 1'b1;
          end
        end
      end
      if (ep0_tok) begin
        in_wait_q <= 1'b0;
        expect_q  <= uce_pkg::UCE_PID_NONE;
        if (tok_in.pid == uce_pkg::UCE_PID_SETUP) begin
          expect_q <= uce_pkg::UCE_PID_SETUP;
        end else if (stall_req_q &&
                     tok_in.pid != uce_pkg::UCE_PID_NONE) begin
          stall_now();
        end else if (tok_in.pid == uce_pkg::UCE_PID_IN) begin
          unique case (state_q)
            uce_pkg::UCE_ST_TX: begin
              if (tx_rdy_q) begin
                resp_q.kind <= uce_pkg::UCE_RSP_DATA;
                in_wait_q   <= 1'b1;
              end else begin
                resp_q.kind <= uce_pkg::UCE_RSP_NAK;
              end
            end
            uce_pkg::UCE_ST_STATUS: begin
              if (status_in_q)
                send_zlp();
              else
                stall_now();
            end
            uce_pkg::UCE_ST_IDLE: begin
              if (last_q)
                send_zlp();
              else
                stall_now();
            end
            uce_pkg::UCE_ST_RX: begin
              abort_now();
            end
          endcase
        end else if (tok_in.pid == uce_pkg::UCE_PID_OUT) begin
          unique case (state_q)
            uce_pkg::UCE_ST_RX: begin
              expect_q <= uce_pkg::UCE_PID_OUT;
            end
            uce_pkg::UCE_ST_STATUS: begin
              if (status_in_q)
                stall_now();
              else
                expect_q <= uce_pkg::UCE_PID_OUT;
            end
            uce_pkg::UCE_ST_TX: begin
              abort_now();
            end
            uce_pkg::UCE_ST_IDLE: begin
              stall_now();
            end
          endcase
        end
      end else if (pkt_in.done && expect_q != uce_pkg::UCE_PID_NONE) begin
        expect_q <= uce_pkg::UCE_PID_NONE;
        if (expect_q == uce_pkg::UCE_PID_SETUP) begin
          // short or long setups are dropped with no answer
          if (pkt_in.len == uce_pkg::SETUP_LEN) begin
            if (state_q != uce_pkg::UCE_ST_IDLE || last_q)
              abort_q <= 1'b1;
            state_q     <= uce_pkg::UCE_ST_IDLE;
            last_q      <= 1'b0;
            tx_rdy_q    <= 1'b0;
            dir_in_q    <= pkt_in.setup_dir_in;
            rx_rdy_q    <= 1'b1;
            rx_count_q  <= pkt_in.len[5:0];
            ep0_irq_q   <= 1'b1;
            resp_q.kind <= uce_pkg::UCE_RSP_ACK;
          end
        end else if (state_q == uce_pkg::UCE_ST_STATUS) begin
          if (pkt_in.data1 && pkt_in.len == 7'h00) begin
            state_q     <= uce_pkg::UCE_ST_IDLE;
            last_q      <= 1'b0;
            ep0_irq_q   <= 1'b1;
            resp_q.kind <= uce_pkg::UCE_RSP_ACK;
          end else begin
            stall_now();
          end
        end else if (pkt_in.len > uce_pkg::EP0_MAX_PKT) begin
          stall_now();
        end else if (rx_rdy_q) begin
          // one buffer only: the host retries until firmware releases
          resp_q.kind <= uce_pkg::UCE_RSP_NAK;
        end else begin
          rx_rdy_q    <= 1'b1;
          rx_count_q  <= pkt_in.len[5:0];
          ep0_irq_q   <= 1'b1;
          resp_q.kind <= uce_pkg::UCE_RSP_ACK;
        end
      end else if (in_wait_q && in_ack_in) begin
        in_wait_q <= 1'b0;
        ep0_irq_q <= 1'b1;
        if (state_q == uce_pkg::UCE_ST_TX) begin
          tx_rdy_q <= 1'b0;
          if (last_q) begin
            state_q     <= uce_pkg::UCE_ST_STATUS;
            status_in_q <= 1'b0;
          end
        end else begin
          state_q <= uce_pkg::UCE_ST_IDLE;
          last_q  <= 1'b0;
        end
      end
      if (data_tok) begin
        // other endpoints stay shut until an address is given
        if (tok_in.pid == uce_pkg::UCE_PID_IN) begin
          resp_q.ep_pass <= addressed_out && in_en_q[tok_ep3];
          resp_q.ep_iso  <= in_iso_q[tok_ep3];
        end else if (tok_in.pid == uce_pkg::UCE_PID_OUT) begin
          resp_q.ep_pass <= addressed_out && out_en_q[tok_ep3];
          resp_q.ep_iso  <= out_iso_q[tok_ep3];
        end
      end
    end
  end

  task automatic stall_now();
    resp_q.kind  <= uce_pkg::UCE_RSP_STALL;
    stall_sent_q <= 1'b1;
    ep0_irq_q    <= 1'b1;
    state_q      <= uce_pkg::UCE_ST_IDLE;
    last_q       <= 1'b0;
    tx_rdy_q     <= 1'b0;
  endtask

  task automatic abort_now();
    abort_q   <= 1'b1;
    ep0_irq_q <= 1'b1;
    state_q   <= uce_pkg::UCE_ST_IDLE;
    last_q    <= 1'b0;
    tx_rdy_q  <= 1'b0;
  endtask

  task automatic send_zlp();
    resp_q.kind <= uce_pkg::UCE_RSP_DATA;
    resp_q.zlp  <= 1'b1;
    in_wait_q   <= 1'b1;
  endtask

  // sticky flags; a set in the read cycle survives the read clear
  always_ff @(posedge clk_in) begin
    if (clr) begin
      irq_ep0_flag_q    <= 1'b0;
      irq_resume_flag_q <= 1'b0;
    end else begin
      if (rd_in && hit(addr_in, uce_pkg::OFF_IRQ_IN))
        irq_ep0_flag_q <= 1'b0;
      if (rd_in && hit(addr_in, uce_pkg::OFF_IRQ_COMM))
        irq_resume_flag_q <= 1'b0;
      if (ep0_irq_q)
        irq_ep0_flag_q <= 1'b1;
      if (resume_in && !resume_q)
        irq_resume_flag_q <= 1'b1;
    end
  end

  always_comb begin
    rd_data_d = uce_pkg::BYTE_ZERO;
    if (hit(addr_in, uce_pkg::OFF_FUNC_ADDR)) begin
      rd_data_d = {1'b0, func_addr_q};
    end else if (hit(addr_in, uce_pkg::OFF_CTRL_CS)) begin
      rd_data_d = {2'b00, abort_q, last_q, stall_req_q, stall_sent_q,
                   tx_rdy_q, rx_rdy_q};
    end else if (hit(addr_in, uce_pkg::OFF_EP_SEL)) begin
      rd_data_d = {5'h00, ep_sel_q};
    end else if (hit(addr_in, uce_pkg::OFF_RX_COUNT)) begin
      rd_data_d = {2'b00, rx_count_q};
    end else if (hit(addr_in, uce_pkg::OFF_IRQ_COMM)) begin
      rd_data_d[uce_pkg::COMM_RESUME] = irq_resume_flag_q;
    end else if (hit(addr_in, uce_pkg::OFF_IRQ_IN)) begin
      rd_data_d[uce_pkg::EP0_IRQ_BIT] = irq_ep0_flag_q;
    end else if (idx_ok && hit(addr_in, uce_pkg::OFF_IN_LOW)) begin
      rd_data_d[uce_pkg::EP_DIR_EN_BIT] = in_en_q[ep_sel_q];
    end else if (idx_ok && hit(addr_in, uce_pkg::OFF_IN_HIGH)) begin
      rd_data_d[uce_pkg::EP_ISO_BIT] = in_iso_q[ep_sel_q];
    end else if (idx_ok && hit(addr_in, uce_pkg::OFF_OUT_LOW)) begin
      rd_data_d[uce_pkg::EP_DIR_EN_BIT] = out_en_q[ep_sel_q];
    end else if (idx_ok && hit(addr_in, uce_pkg::OFF_OUT_HIGH)) begin
      rd_data_d[uce_pkg::EP_ISO_BIT] = out_iso_q[ep_sel_q];
    end
  end

  always_ff @(posedge clk_in) begin
    rd_data_q <= (rd_in && !clr) ? rd_data_d : uce_pkg::BYTE_ZERO;
  end
endmodule // uce_engine

//--- tb/uce_engine_checker.sv
/*
  uce_engine_checker: port assertions for the control endpoint engine.
  assumes one clock with a sync reset; bound to every uce_engine.
*/
`timescale 1ns/100ps
module uce_engine_checker (
  input wire logic                   clk_in,
  input wire logic                   rst_in,
  input wire logic                   usb_enable_in,
  input wire logic [7:0]             addr_in,
  input wire logic [7:0]             wr_data_in,
  input wire logic                   wr_in,
  input wire logic                   rd_in,
  input wire logic [7:0]             rd_data_out,
  input wire uce_pkg::uce_token_type  tok_in,
  input wire uce_pkg::uce_packet_type pkt_in,
  input wire logic                   in_ack_in,
  input wire logic                   resume_in,
  input wire uce_pkg::uce_resp_type  resp_out,
  input wire logic                   port0_bit7_out,
  input wire logic                   addressed_out
);
  default clocking cb @(posedge clk_in); endclocking
  // disabled engine behaves as reset, so most checks pause then
  default disable iff (rst_in || !usb_enable_in);

  sequence s_setup_tok;
    tok_in.valid && tok_in.pid == uce_pkg::UCE_PID_SETUP &&
      tok_in.ep == 4'h0 && tok_in.addr == 7'h00 && !addressed_out;
  endsequence
  sequence s_pkt8;
    pkt_in.done && pkt_in.len == uce_pkg::SETUP_LEN;
  endsequence
  sequence s_pkt_bad;
    pkt_in.done && pkt_in.len != uce_pkg::SETUP_LEN;
  endsequence

  property p_resume;
    $rose(resume_in) |=> port0_bit7_out;
  endproperty
  property p_resume_fall;
    $fell(resume_in) |=> !port0_bit7_out;
  endproperty
  property p_unaddr_ep;
    tok_in.valid && tok_in.ep != 4'h0 && !addressed_out
      |=> !resp_out.ep_pass;
  endproperty
  property p_addr_set;
    wr_in && addr_in == uce_pkg::OFF_FUNC_ADDR && wr_data_in[6:0] != 7'h00
      |=> addressed_out;
  endproperty
  property p_addr_zero;
    wr_in && addr_in == uce_pkg::OFF_FUNC_ADDR && wr_data_in[6:0] == 7'h00
      |=> !addressed_out;
  endproperty
  property p_setup_ack;
    s_setup_tok ##1 s_pkt8 |=> resp_out.kind == uce_pkg::UCE_RSP_ACK;
  endproperty
  property p_setup_len;
    s_setup_tok ##1 s_pkt_bad |=> resp_out.kind == uce_pkg::UCE_RSP_NONE;
  endproperty
  property p_disable;
    @(posedge clk_in) disable iff (rst_in)
      !usb_enable_in |=> resp_out.kind == uce_pkg::UCE_RSP_NONE &&
        rd_data_out == 8'h00 && !port0_bit7_out;
  endproperty

  a_resume: assert property (p_resume)
    else $error("resume edge not passed to port bit");
  a_resume_fall: assert property (p_resume_fall)
    else $error("port bit stayed high after resume ended");
  a_unaddr_ep: assert property (p_unaddr_ep)
    else $error("endpoint opened before addressing");
  a_addr_set: assert property (p_addr_set)
    else $error("non-zero address did not enter addressed");
  a_addr_zero: assert property (p_addr_zero)
    else $error("zero address still addressed");
  a_setup_ack: assert property (p_setup_ack)
    else $error("eight byte setup not acknowledged");
  a_setup_len: assert property (p_setup_len)
    else $error("wrong length setup was answered");
  a_disable: assert property (p_disable)
    else $error("outputs active while disabled");
endmodule // uce_engine_checker

bind uce_engine uce_engine_checker i_chk (
  .clk_in(clk_in), .rst_in(rst_in), .usb_enable_in(usb_enable_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
  .rd_in(rd_in), .rd_data_out(rd_data_out), .tok_in(tok_in),
  .pkt_in(pkt_in), .in_ack_in(in_ack_in), .resume_in(resume_in),
  .resp_out(resp_out), .port0_bit7_out(port0_bit7_out),
  .addressed_out(addressed_out)
);

//--- tb/uce_host_model.sv
/*
  uce_host_model: host side of the link, issuing tokens and packets.
  assumes the engine answers one cycle after a token or packet end.
*/
`timescale 1ns/100ps
module uce_host_model (
  input  wire logic                   clk_in,
  input  wire logic                   slow_in,
  input  wire logic                   resume_req_in,
  input  wire uce_pkg::uce_resp_type  resp_in,
  output uce_pkg::uce_token_type      tok_out,
  output uce_pkg::uce_packet_type     pkt_out,
  output logic                        ack_out,
  output logic                        resume_out
);
  logic ack_q;

  initial begin
    tok_out = '{1'b0, uce_pkg::UCE_PID_NONE, 7'h7f, 4'hf};
    pkt_out = '0;
    ack_out = 1'b0;
    ack_q = 1'b0;
  end

  assign resume_out = resume_req_in;

  // host acks every data packet; slow mode adds one cycle
  always @(posedge clk_in) begin
    ack_q <= resp_in.kind == uce_pkg::UCE_RSP_DATA;
    ack_out <= slow_in ? ack_q : resp_in.kind == uce_pkg::UCE_RSP_DATA;
  end

  // released fields show inverted values and pid shows none, never the last ones
  task automatic xact(input uce_pkg::uce_pid_type pid,
                      input logic [3:0] ep, input logic [6:0] fa,
                      input logic has_pkt, input logic [6:0] len,
                      input logic d1, input logic dir,
                      output uce_pkg::uce_resp_type rsp);
    @(posedge clk_in);
    tok_out <= '{1'b1, pid, fa, ep};
    @(posedge clk_in);
    tok_out <= '{1'b0, uce_pkg::UCE_PID_NONE, ~fa, ~ep};
    if (has_pkt) begin
      pkt_out <= '{1'b1, len, d1, dir};
      @(posedge clk_in);
      pkt_out <= '{1'b0, ~len, ~d1, ~dir};
    end
    #1 rsp = resp_in;
  endtask
endmodule // uce_host_model

//--- tb/test_uce_engine.sv
/*
  test_uce_engine: register and link scenarios for the engine.
  assumes the host model answers data packets with acks.
*/
`timescale 1ns/100ps
module test_uce_engine;
  localparam logic [7:0] cs = uce_pkg::OFF_CTRL_CS;
  localparam logic [7:0] fin = uce_pkg::OFF_IRQ_IN;
  localparam logic [7:0] rxr = 8'h01 << uce_pkg::CS_RX_READY;
  localparam logic [7:0] txr = 8'h01 << uce_pkg::CS_TX_READY;
  localparam logic [7:0] sts = 8'h01 << uce_pkg::CS_STALL_SENT;
  localparam logic [7:0] req = 8'h01 << uce_pkg::CS_STALL_REQ;
  localparam logic [7:0] lst = 8'h01 << uce_pkg::CS_LAST_DATA;
  localparam logic [7:0] abt = 8'h01 << uce_pkg::CS_SETUP_ABORT;
  localparam logic [7:0] rel = 8'h01 << uce_pkg::CS_RX_RELEASE;
  localparam logic [7:0] clr = 8'h01 << uce_pkg::CS_ABORT_CLEAR;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic usb_enable_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wr_data_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic slow = 1'b0;
  logic resume_req = 1'b0;
  logic [6:0] fa = 7'h00;
  logic [7:0] rd_data_out;
  logic resume, ack, port0, addressed;
  uce_pkg::uce_token_type tok;
  uce_pkg::uce_packet_type pkt;
  uce_pkg::uce_resp_type resp, rs;
  int err_total = 0;
  int samples_checked = 0;

  always #12.5 clk_in = ~clk_in;

  uce_engine i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .usb_enable_in(usb_enable_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .tok_in(tok),
    .pkt_in(pkt), .in_ack_in(ack), .resume_in(resume),
    .resp_out(resp), .port0_bit7_out(port0), .addressed_out(addressed));
  uce_host_model i_host (
    .clk_in(clk_in), .slow_in(slow), .resume_req_in(resume_req),
    .resp_in(resp), .tok_out(tok), .pkt_out(pkt), .ack_out(ack),
    .resume_out(resume));

  task automatic chk(input string nm, input logic [7:0] got,
                     input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk($sformatf("reg_%h", a), rd_data_out, exp);
  endtask
  // control endpoint transaction with its expected answer
  task automatic tx(input uce_pkg::uce_pid_type p, input logic [6:0] n,
                    input logic d, input uce_pkg::uce_rsp_type k);
    i_host.xact(p, 4'h0, fa, p != uce_pkg::UCE_PID_IN, n,
                d && p == uce_pkg::UCE_PID_OUT, d, rs);
    chk("resp_kind", {5'h00, rs.kind}, {5'h00, k});
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(cs, 8'h00);
    rd(uce_pkg::OFF_FUNC_ADDR, 8'h00);
    $display("test reset done");
    @(posedge clk_in);
    resume_req <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 chk("port0_bit7", {7'h00, port0}, 8'h01);
    rd(uce_pkg::OFF_IRQ_COMM, 8'h01 << uce_pkg::COMM_RESUME);
    rd(uce_pkg::OFF_IRQ_COMM, 8'h00);
    resume_req <= 1'b0;
    $display("test resume done");
    tx(uce_pkg::UCE_PID_SETUP, 7'h08, 1'b0, uce_pkg::UCE_RSP_ACK);
    rd(cs, rxr);
    rd(fin, 8'h01);
    rd(fin, 8'h00);
    wr(cs, rel | lst);
    rd(cs, lst);
    tx(uce_pkg::UCE_PID_IN, 7'h00, 1'b0, uce_pkg::UCE_RSP_DATA);
    chk("zlp", {7'h00, rs.zlp}, 8'h01);
    repeat (3) @(posedge clk_in);
    rd(cs, 8'h00);
    rd(fin, 8'h01);
    $display("test no data done");
    tx(uce_pkg::UCE_PID_SETUP, 7'h07, 1'b0, uce_pkg::UCE_RSP_NONE);
    rd(cs, 8'h00);
    rd(fin, 8'h00);
    $display("test bad setup done");
    tx(uce_pkg::UCE_PID_SETUP, 7'h08, 1'b1, uce_pkg::UCE_RSP_ACK);
    wr(cs, rel);
    tx(uce_pkg::UCE_PID_IN, 7'h00, 1'b0, uce_pkg::UCE_RSP_NAK);
    wr(cs, txr);
    slow <= 1'b1;
    tx(uce_pkg::UCE_PID_IN, 7'h00, 1'b0, uce_pkg::UCE_RSP_DATA);
    repeat (4) @(posedge clk_in);
    rd(cs, 8'h00);
    rd(fin, 8'h01);
    slow <= 1'b0;
    tx(uce_pkg::UCE_PID_OUT, 7'h00, 1'b0, uce_pkg::UCE_RSP_NONE);
    rd(cs, abt);
    rd(fin, 8'h01);
    wr(cs, clr);
    rd(cs, 8'h00);
    tx(uce_pkg::UCE_PID_SETUP, 7'h08, 1'b1, uce_pkg::UCE_RSP_ACK);
    wr(cs, rel);
    wr(cs, txr | lst);
    tx(uce_pkg::UCE_PID_IN, 7'h00, 1'b0, uce_pkg::UCE_RSP_DATA);
    repeat (3) @(posedge clk_in);
    tx(uce_pkg::UCE_PID_OUT, 7'h03, 1'b1, uce_pkg::UCE_RSP_STALL);
    rd(cs, sts);
    rd(fin, 8'h01);
    wr(cs, 8'h00);
    rd(cs, 8'h00);
    $display("test in stage done");
    tx(uce_pkg::UCE_PID_SETUP, 7'h08, 1'b0, uce_pkg::UCE_RSP_ACK);
    wr(cs, rel);
    tx(uce_pkg::UCE_PID_OUT, 7'h20, 1'b0, uce_pkg::UCE_RSP_ACK);
    rd(cs, rxr);
    rd(uce_pkg::OFF_RX_COUNT, 8'h20);
    wr(cs, rel);
    tx(uce_pkg::UCE_PID_OUT, 7'h05, 1'b0, uce_pkg::UCE_RSP_ACK);
    wr(cs, rel | lst);
    tx(uce_pkg::UCE_PID_IN, 7'h00, 1'b0, uce_pkg::UCE_RSP_DATA);
    repeat (3) @(posedge clk_in);
    rd(cs, 8'h00);
    tx(uce_pkg::UCE_PID_SETUP, 7'h08, 1'b0, uce_pkg::UCE_RSP_ACK);
    wr(cs, rel);
    tx(uce_pkg::UCE_PID_OUT, 7'h21, 1'b0, uce_pkg::UCE_RSP_STALL);
    rd(cs, sts);
    wr(cs, 8'h00);
    $display("test out stage done");
    tx(uce_pkg::UCE_PID_SETUP, 7'h08, 1'b1, uce_pkg::UCE_RSP_ACK);
    wr(cs, rel);
    wr(cs, req);
    tx(uce_pkg::UCE_PID_IN, 7'h00, 1'b0, uce_pkg::UCE_RSP_STALL);
    rd(cs, sts | req);
    wr(cs, 8'h00);
    $display("test stall request done");
    tx(uce_pkg::UCE_PID_SETUP, 7'h08, 1'b1, uce_pkg::UCE_RSP_ACK);
    wr(cs, rel);
    wr(cs, txr);
    usb_enable_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    usb_enable_in <= 1'b1;
    rd(cs, 8'h00);
    $display("test disable done");
    i_host.xact(uce_pkg::UCE_PID_IN, 4'h1, fa, 1'b0, 7'h00, 1'b0, 1'b0, rs);
    chk("ep_pass", {7'h00, rs.ep_pass}, 8'h00);
    wr(uce_pkg::OFF_EP_SEL, 8'h01);
    wr(uce_pkg::OFF_IN_LOW, 8'h01);
    wr(uce_pkg::OFF_IN_HIGH, 8'h40);
    rd(uce_pkg::OFF_IN_HIGH, 8'h40);
    wr(uce_pkg::OFF_EP_SEL, 8'h00);
    rd(uce_pkg::OFF_IN_HIGH, 8'h00);
    rd(8'h0b, 8'h00);
    wr(uce_pkg::OFF_FUNC_ADDR, 8'h05);
    #1 chk("addressed", {7'h00, addressed}, 8'h01);
    fa = 7'h05;
    i_host.xact(uce_pkg::UCE_PID_IN, 4'h1, fa, 1'b0, 7'h00, 1'b0, 1'b0, rs);
    chk("ep_pass_iso", {6'h00, rs.ep_pass, rs.ep_iso}, 8'h03);
    i_host.xact(uce_pkg::UCE_PID_IN, 4'h1, 7'h06, 1'b0, 7'h00, 1'b0, 1'b0, rs);
    chk("other_addr", {2'b00, rs}, 8'h00);
    wr(uce_pkg::OFF_FUNC_ADDR, 8'h00);
    #1 chk("addressed", {7'h00, addressed}, 8'h00);
    $display("test address done");
    print_verdict();
  end
endmodule // test_uce_engine
